//--- include/arr_pkg.sv
// Purpose: Shared constants and carriers for the converter result and trigger register block.
// Assumes: AXI4-Lite with 32-bit data; each byte register sits in the low bits of one word.
// Notes: Register offsets are local choices, since none are printed for these registers.
package arr_pkg;
   // Byte addresses of the register words.
   localparam logic [7:0] OFF_RESULT_LOW  = 8'h00;
   localparam logic [7:0] OFF_RESULT_HIGH = 8'h04;
   localparam logic [7:0] OFF_CONTROL_A   = 8'h08;
   localparam logic [7:0] OFF_CONTROL_B   = 8'h0C;
   localparam logic [7:0] OFF_INPUT_OFF_0 = 8'h10;
   localparam logic [7:0] OFF_INPUT_OFF_1 = 8'h14;
   localparam logic [7:0] OFF_MISC        = 8'h18;
   localparam logic [7:0] OFF_MUX         = 8'h1C;
   localparam logic [7:0] OFF_STATUS      = 8'h20;
   // Field positions.
   localparam int BIT_BIPOLAR     = 7;
   localparam int BIT_CMP_MUX     = 6;
   localparam int BIT_CONV_ON     = 7;
   localparam int BIT_AUTO_TRIG   = 5;
   localparam int BIT_DONE_FLAG   = 4;
   localparam int BIT_LEFT_ALIGN  = 5;
   localparam int BIT_EXT_REF     = 2;
   localparam int BIT_INT_REF_OUT = 1;
   localparam int BIT_ISRC        = 0;
   // Writable masks; zeros are reserved and read as zero.
   localparam logic [7:0] MASK_CONTROL_A  = 8'hB0;
   localparam logic [7:0] MASK_CONTROL_B  = 8'hF7;
   localparam logic [7:0] MASK_INPUT_OFF_1 = 8'h70;
   localparam logic [7:0] MASK_MISC       = 8'h07;
   localparam logic [7:0] MASK_MUX        = 8'h3F;
   localparam logic [7:0] RESET_BYTE      = 8'h00;
   localparam logic [9:0] RESULT_FULL     = 10'h3FF;
   localparam logic [2:0] TRIG_FREE_RUN   = 3'h0;
   localparam int         TRIG_COUNT      = 8;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
   // Comparator interrupt mode codes.
   localparam logic [1:0] CMP_TOGGLE      = 2'h0;
   localparam logic [1:0] CMP_FALL        = 2'h2;
   localparam logic [1:0] CMP_RISE        = 2'h3;

   // Raw result handed over by the analog core.
   typedef struct packed {
      logic       done;      // One-cycle pulse, conversion finished.
      logic       negative;  // Negative input exceeded positive input.
      logic [9:0] value;     // Raw magnitude or two's complement value.
   } arr_core_result_type;

   // Reference routing outputs.
   typedef struct packed {
      logic ext_reference_in_on;
      logic int_reference_out_on;
      logic current_source_on;
   } arr_reference_type;
endpackage : arr_pkg

//--- hw/arr_regs.sv
// Purpose: Result registers, auto trigger, input disables and reference control of the converter.
// Assumes: Single clock, synchronous active-high reset, AXI4-Lite slave.
// Notes: Analog core, channel multiplexer and prescaler sit outside.
// How it works
// - Finished conversion loads the result pair.
// - Low read locks result until high read.
// - Right alignment puts bits nine, eight in high bits 1:0.
// - Left alignment puts bits 9:2 high.
// - Result bytes read-only, reset to zero.
// - Unipolar result saturates when negative larger.
// - Bipolar result is two's complement.
// - Control B bit three reads zero.
// - Source select matters only with auto trigger.
// - Rising selected flag starts a conversion.
// - Switching from a clear to a set source triggers.
// - Switching to free running never triggers.
// - Eight trigger source codes decoded.
// - Low channel disables zero port inputs.
// - High channel disables zero port inputs.
// - Misc bits 7:3 read zero.
// - External reference enable selects input pin.
// - Internal reference output enable drives pin.
// - Comparator output follows input comparison.
// - Comparator event on rise, fall or toggle.
// - Alignment change affects layout immediately.
// - Auto trigger starts on selected edges.
`timescale 1ns/1ps
module arr_regs
   import arr_pkg::*;
(
   input  wire logic                i_mclk,
   input  wire logic                i_reset,
   // AXI4-Lite slave.
   input  wire logic [7:0]          i_awaddr,
   input  wire logic                i_awvalid,
   output logic                     o_awready,
   input  wire logic [31:0]         i_wdata,
   input  wire logic [3:0]          i_wstrb,
   input  wire logic                i_wvalid,
   output logic                     o_wready,
   output logic [1:0]               o_bresp,
   output logic                     o_bvalid,
   input  wire logic                i_bready,
   input  wire logic [7:0]          i_araddr,
   input  wire logic                i_arvalid,
   output logic                     o_arready,
   output logic [31:0]              o_rdata,
   output logic [1:0]               o_rresp,
   output logic                     o_rvalid,
   input  wire logic                i_rready,
   // Analog core side.
   input  wire arr_core_result_type i_core,
   input  wire logic                i_core_busy,
   output logic                     o_conv_start,
   output logic                     o_converter_on,
   output logic                     o_bipolar_select,
   output logic [4:0]               o_channel_select,
   output logic                     o_comparator_mux_on,
   output arr_reference_type        o_reference,
   // Trigger flags, index = trigger_source_select code (bit 0 unused).
   input  wire logic [7:0]          i_trigger_flags,
   // Comparator raw input and its mode.
   input  wire logic                i_cmp_pos_higher,
   input  wire logic [1:0]          i_cmp_mode,
   output logic                     o_comparator_out,
   output logic                     o_cmp_event,
   // Port pins, raw and masked.
   input  wire logic [10:0]         i_pin_raw,
   output logic [10:0]              o_pin_read
);

   // Decode an address to the byte register it selects, for both read and write.
   function automatic logic [3:0] reg_sel(input logic [7:0] addr);
      case (addr)
         OFF_RESULT_LOW:  reg_sel = 4'h1;
         OFF_RESULT_HIGH: reg_sel = 4'h2;
         OFF_CONTROL_A:   reg_sel = 4'h3;
         OFF_CONTROL_B:   reg_sel = 4'h4;
         OFF_INPUT_OFF_0: reg_sel = 4'h5;
         OFF_INPUT_OFF_1: reg_sel = 4'h6;
         OFF_MISC:        reg_sel = 4'h7;
         OFF_MUX:         reg_sel = 4'h8;
         OFF_STATUS:      reg_sel = 4'h9;
         default:         reg_sel = 4'h0;
      endcase
   endfunction : reg_sel

   // Software-visible state.
   logic [7:0] conv_control_a, next_conv_control_a;         // Enable, auto trigger, done flag.
   logic [7:0] conv_control_b, next_conv_control_b;         // Bipolar, mux, source select.
   logic [7:0] digital_input_off_0, next_digital_input_off_0;
   logic [7:0] digital_input_off_1, next_digital_input_off_1;
   logic [7:0] analog_misc_control, next_analog_misc_control;
   logic [7:0] mux_control, next_mux_control;               // Alignment and channel select.
   logic [9:0] result, next_result;                         // Stored raw result.
   logic       locked, next_locked;                         // Low byte read, high pending.
   logic       cmp_sync, next_cmp_sync;                     // Synchronised comparator.
   logic       cmp_out, next_cmp_out;
   logic       trig_prev, next_trig_prev;                   // Last selected trigger level.
   // Bus state.
   logic       aw_held, next_aw_held;
   logic       w_held, next_w_held;
   logic [7:0] aw_addr, next_aw_addr;
   logic [7:0] w_byte, next_w_byte;
   logic       w_lane, next_w_lane;
   logic       bvalid, next_bvalid;
   logic [1:0] bresp, next_bresp;
   logic       rvalid, next_rvalid;
   logic [1:0] rresp, next_rresp;
   logic [31:0] rdata, next_rdata;

   logic       auto_on, trig_level, trig_start, do_write, do_read;
   logic [7:0] low_view, high_view, read_byte;
   logic [2:0] src;

   assign auto_on = conv_control_a[BIT_AUTO_TRIG];
   assign src     = conv_control_b[2:0];

   // Selected trigger level; free running uses the done flag of this block.
   always_comb begin
      if (src == TRIG_FREE_RUN) begin
         trig_level = conv_control_a[BIT_DONE_FLAG];
      end else begin
         trig_level = i_trigger_flags[src];
      end
   end

   // A start fires on a rising selected level, only with auto trigger and converter on.
   // One register holds the previous level of whichever source was selected, so a switch from a clear flag onto a set flag reads as an edge,
   // while switching onto free running is masked explicitly.
   always_comb begin
      trig_start = auto_on && conv_control_a[BIT_CONV_ON]
                   && trig_level && !trig_prev;
      // A switch onto free running arms the tracker, so a set done flag is no edge.
      if (next_conv_control_b[2:0] == TRIG_FREE_RUN && src != TRIG_FREE_RUN) begin
         next_trig_prev = 1'b1;
      end else begin
         next_trig_prev = trig_level;
      end
   end

   // Result presentation follows the live alignment bit, not a snapshot.
   always_comb begin
      if (mux_control[BIT_LEFT_ALIGN]) begin
         high_view = result[9:2];
         low_view  = {result[1:0], 6'h00};
      end else begin
         high_view = {6'h00, result[9:8]};
         low_view  = result[7:0];
      end
   end

   assign do_write = aw_held && w_held && !bvalid;
   assign do_read  = i_arvalid && !rvalid;

   // Read multiplexer; reserved bits come back as zero through the masks.
   always_comb begin
      case (reg_sel(i_araddr))
         4'h1:    read_byte = low_view;
         4'h2:    read_byte = high_view;
         4'h3:    read_byte = conv_control_a;
         4'h4:    read_byte = conv_control_b & MASK_CONTROL_B;
         4'h5:    read_byte = digital_input_off_0;
         4'h6:    read_byte = digital_input_off_1 & MASK_INPUT_OFF_1;
         4'h7:    read_byte = analog_misc_control & MASK_MISC;
         4'h8:    read_byte = mux_control;
         4'h9:    read_byte = {6'h00, locked, i_core_busy};
         default: read_byte = RESET_BYTE;
      endcase
   end

   // Next state of registers, lock, bus channels and comparator.
   always_comb begin
      next_conv_control_a      = conv_control_a;
      next_conv_control_b      = conv_control_b;
      next_digital_input_off_0 = digital_input_off_0;
      next_digital_input_off_1 = digital_input_off_1;
      next_analog_misc_control = analog_misc_control;
      next_mux_control         = mux_control;
      next_result              = result;
      next_locked              = locked;
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_byte  = w_byte;
      next_w_lane  = w_lane;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      next_cmp_sync = i_cmp_pos_higher;
      next_cmp_out  = cmp_sync;
      // Write address and data are taken in either order.
      if (i_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = i_awaddr;
      end
      if (i_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_byte = i_wdata[7:0];
         next_w_lane = i_wstrb[0];
      end
      // Register writes; only byte lane zero carries data.
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (reg_sel(aw_addr) == 4'h0) ? RESP_SLVERR : RESP_OKAY;
         if (w_lane) begin
            case (reg_sel(aw_addr))
               4'h3: begin
                  next_conv_control_a = (w_byte & MASK_CONTROL_A)
                                        | (conv_control_a & ~MASK_CONTROL_A);
                  // Done flag clears by writing one, and is never set by software.
                  next_conv_control_a[BIT_DONE_FLAG] = conv_control_a[BIT_DONE_FLAG]
                                                       & ~w_byte[BIT_DONE_FLAG];
               end
               4'h4: next_conv_control_b      = w_byte & MASK_CONTROL_B;
               4'h5: next_digital_input_off_0 = w_byte;
               4'h6: next_digital_input_off_1 = w_byte & MASK_INPUT_OFF_1;
               4'h7: next_analog_misc_control = w_byte & MASK_MISC;
               4'h8: next_mux_control         = w_byte & MASK_MUX;
               default: next_mux_control      = mux_control;
            endcase
         end
      end
      if (bvalid && i_bready) begin
         next_bvalid = 1'b0;
      end
      // Reads; the low byte locks, the high byte releases.
      if (do_read) begin
         next_rvalid = 1'b1;
         next_rdata  = {24'h000000, read_byte};
         next_rresp  = (reg_sel(i_araddr) == 4'h0) ? RESP_SLVERR : RESP_OKAY;
         if (reg_sel(i_araddr) == 4'h1) begin
            next_locked = 1'b1;
         end
         if (reg_sel(i_araddr) == 4'h2) begin
            next_locked = 1'b0;
         end
      end
      if (rvalid && i_rready) begin
         next_rvalid = 1'b0;
      end
      // New result is stored only while unlocked; the done flag is set either way,
      // and a set wins over a same-cycle clear.
      if (i_core.done) begin
         next_conv_control_a[BIT_DONE_FLAG] = 1'b1;
         if (!locked) begin
            if (!conv_control_b[BIT_BIPOLAR] && i_core.negative) begin
               next_result = RESULT_FULL;
            end else begin
               next_result = i_core.value;
            end
         end
      end
   end

   // Register every state element except cmp_prev.
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         conv_control_a      <= RESET_BYTE;
         conv_control_b      <= RESET_BYTE;
         digital_input_off_0 <= RESET_BYTE;
         digital_input_off_1 <= RESET_BYTE;
         analog_misc_control <= RESET_BYTE;
         mux_control         <= RESET_BYTE;
         result              <= '0;
         locked              <= 1'b0;
         cmp_sync            <= 1'b0;
         cmp_out             <= 1'b0;
         trig_prev           <= 1'b0;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= RESET_BYTE;
         w_byte  <= RESET_BYTE;
         w_lane  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rresp   <= RESP_OKAY;
         rdata   <= '0;
      end else begin
         conv_control_a      <= next_conv_control_a;
         conv_control_b      <= next_conv_control_b;
         digital_input_off_0 <= next_digital_input_off_0;
         digital_input_off_1 <= next_digital_input_off_1;
         analog_misc_control <= next_analog_misc_control;
         mux_control         <= next_mux_control;
         result              <= next_result;
         locked              <= next_locked;
         cmp_sync            <= next_cmp_sync;
         cmp_out             <= next_cmp_out;
         trig_prev           <= next_trig_prev;
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_addr <= next_aw_addr;
         w_byte  <= next_w_byte;
         w_lane  <= next_w_lane;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end

   // Comparator event detection on the synchronised output.
   logic cmp_prev;
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         cmp_prev <= 1'b0;
      end else begin
         cmp_prev <= cmp_out;
      end
   end
   always_comb begin
      case (i_cmp_mode)
         CMP_TOGGLE: o_cmp_event = cmp_out ^ cmp_prev;
         CMP_FALL:   o_cmp_event = !cmp_out && cmp_prev;
         CMP_RISE:   o_cmp_event = cmp_out && !cmp_prev;
         default:    o_cmp_event = 1'b0;
      endcase
   end

   // Port input masking by the digital input disables.
   assign o_pin_read[7:0]  = i_pin_raw[7:0] & ~digital_input_off_0;
   assign o_pin_read[10:8] = i_pin_raw[10:8] & ~digital_input_off_1[6:4];

   assign o_conv_start        = trig_start;
   assign o_converter_on      = conv_control_a[BIT_CONV_ON];
   assign o_bipolar_select    = conv_control_b[BIT_BIPOLAR];
   assign o_comparator_mux_on = conv_control_b[BIT_CMP_MUX];
   assign o_channel_select    = mux_control[4:0];
   assign o_reference.ext_reference_in_on  = analog_misc_control[BIT_EXT_REF];
   assign o_reference.int_reference_out_on = analog_misc_control[BIT_INT_REF_OUT];
   assign o_reference.current_source_on    = analog_misc_control[BIT_ISRC];
   assign o_comparator_out = cmp_out;
   assign o_awready = !aw_held;
   assign o_wready  = !w_held;
   assign o_bvalid  = bvalid;
   assign o_bresp   = bresp;
   assign o_arready = !rvalid;
   assign o_rvalid  = rvalid;
   assign o_rdata   = rdata;
   assign o_rresp   = rresp;

   // Assertions.
   sequence s_low_read;
      do_read && reg_sel(i_araddr) == 4'h1;
   endsequence
   a_lock_holds_result: assert property (@(posedge i_mclk) disable iff (i_reset)
      locked && !(do_read && reg_sel(i_araddr) == 4'h2) |=> $stable(result))
      else $error("Result changed while locked.");
   a_low_read_locks: assert property (@(posedge i_mclk) disable iff (i_reset)
      s_low_read |=> locked)
      else $error("Low read did not lock.");
   a_right_layout: assert property (@(posedge i_mclk) disable iff (i_reset)
      !mux_control[BIT_LEFT_ALIGN] |-> high_view == {6'h00, result[9:8]})
      else $error("Right layout wrong.");
   a_left_layout: assert property (@(posedge i_mclk) disable iff (i_reset)
      mux_control[BIT_LEFT_ALIGN] |-> low_view[5:0] == 6'h00 && high_view == result[9:2])
      else $error("Left layout wrong.");
   a_unipolar_sat: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_core.done && !locked && i_core.negative && !conv_control_b[BIT_BIPOLAR]
      |=> result == RESULT_FULL)
      else $error("No saturation.");
   a_no_auto_start: assert property (@(posedge i_mclk) disable iff (i_reset)
      !auto_on |-> !o_conv_start)
      else $error("Start without auto trigger.");
   a_free_no_trig: assert property (@(posedge i_mclk) disable iff (i_reset)
      src == TRIG_FREE_RUN && $changed(src) |-> !o_conv_start)
      else $error("Switch to free running triggered.");
   a_pin_masked: assert property (@(posedge i_mclk) disable iff (i_reset)
      (o_pin_read[7:0] & digital_input_off_0) == 8'h00)
      else $error("Disabled pin read nonzero.");
   a_cmp_sync: assert property (@(posedge i_mclk) disable iff (i_reset)
      i_cmp_pos_higher ##2 1'b1 |-> o_comparator_out == $past(i_cmp_pos_higher, 2))
      else $error("Comparator output delay wrong.");
endmodule : arr_regs

//--- verif/arr_core_model.sv
// Purpose: Behavioural analog converter core that answers the register block.
// Assumes: One clock; a conversion takes LATENCY clocks from its start.
// Notes: A start while busy restarts the count, as an aborted conversion would.
`timescale 1ns/1ps
module arr_core_model
   import arr_pkg::*;
#(
   parameter int LATENCY = 4  // Shortened conversion length in clocks.
)
(
   input  wire logic           i_mclk,
   input  wire logic           i_reset,
   input  wire logic           i_start,
   input  wire logic           i_converter_on,
   input  wire logic           i_go,
   input  wire logic [9:0]     i_value,
   input  wire logic           i_negative,
   output arr_core_result_type o_core,
   output logic                o_busy
);
   int count;  // Clocks left in the running conversion.

   // Counts a conversion down and pulses done with the raw result.
   always_ff @(posedge i_mclk) begin
      o_core.done <= 1'b0;
      if (i_reset) begin
         count  <= 0;
         o_core <= '0;
      end else if ((i_start && i_converter_on) || i_go) begin
         count <= LATENCY;
      end else if (count == 1) begin
         count  <= 0;
         o_core <= '{1'b1, i_negative, i_value};
      end else if (count > 0) begin
         count <= count - 1;
      end
   end

   assign o_busy = (count != 0);
endmodule : arr_core_model

//--- verif/arr_regs_tb.sv
// Purpose: Self-checking bench for the converter result and trigger registers.
// Assumes: AXI4-Lite master tasks; readies of responses are held high.
// Notes: Trigger and comparator pulses are counted by small monitors.
`timescale 1ns/1ps
module arr_regs_tb;
   import arr_pkg::*;
   logic i_mclk, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_conv_start;
   logic o_converter_on, o_comparator_out, o_cmp_event, i_core_busy, i_cmp_pos_higher;
   logic go, neg, o_bipolar_select, o_comparator_mux_on;
   logic [4:0]  o_channel_select;
   logic [7:0]  i_awaddr, i_araddr, i_trigger_flags;
   logic [31:0] i_wdata, o_rdata;
   logic [3:0]  i_wstrb;
   logic [1:0]  o_bresp, o_rresp, i_cmp_mode;
   logic [9:0]  val;
   logic [10:0] i_pin_raw, o_pin_read;
   arr_core_result_type i_core;
   arr_reference_type   o_reference;
   int errors, checks, starts, events, s, k;

   arr_regs dut (.i_mclk, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
      .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
      .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_core, .i_core_busy,
      .o_conv_start, .o_converter_on, .o_bipolar_select, .o_channel_select,
      .o_comparator_mux_on, .o_reference, .i_trigger_flags, .i_cmp_pos_higher,
      .i_cmp_mode, .o_comparator_out, .o_cmp_event, .i_pin_raw, .o_pin_read);
   arr_core_model core (.i_mclk, .i_reset, .i_start(o_conv_start), .i_converter_on(o_converter_on),
      .i_go(go), .i_value(val), .i_negative(neg), .o_core(i_core), .o_busy(i_core_busy));

   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end

   // Counts start and comparator pulses; both stand for one cycle only.
   always @(posedge i_mclk) begin
      if (o_conv_start) starts <= starts + 1;
      if (o_cmp_event) events <= events + 1;
   end

   task automatic results;
      if (errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Bounded wait; a hang counts as a mismatch and ends the run.
   task automatic give_up(input logic seen);
      if (seen !== 1'b1) begin
         errors++;
         results();
      end
   endtask : give_up

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      i_awaddr  <= a;
      i_wdata   <= {24'h0, d};
      i_awvalid <= 1'b1;
      i_wvalid  <= 1'b1;
      n = 0;
      do begin
         @(posedge i_mclk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         n++;
      end while (!o_bvalid && n < 40);
      give_up(o_bvalid);
      chk(32'(o_bresp), 32'(RESP_OKAY));
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r);
      int n;
      i_araddr  <= a;
      i_arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge i_mclk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         n++;
      end while (!o_rvalid && n < 40);
      give_up(o_rvalid);
      chk(o_rdata, {24'h0, e});
      chk(32'(o_rresp), 32'(r));
   endtask : rd

   // Asks the core model for one conversion and waits for its done pulse.
   task automatic conv(input logic [9:0] v, input logic n_in);
      int n;
      val <= v;
      neg <= n_in;
      go  <= 1'b1;
      @(posedge i_mclk);
      go <= 1'b0;
      n = 0;
      do begin
         @(posedge i_mclk);
         n++;
      end while (!i_core.done && n < 40);
      give_up(i_core.done);
      @(posedge i_mclk);
   endtask : conv

   initial begin
      {i_awvalid, i_wvalid, i_arvalid, go, neg, i_cmp_pos_higher} = '0;
      {i_awaddr, i_araddr, i_trigger_flags, i_wdata, val, i_cmp_mode} = '0;
      {i_bready, i_rready, i_reset} = 3'h7;
      i_wstrb   = 4'hF;
      i_pin_raw = 11'h7FF;
      repeat (3) @(posedge i_mclk);
      i_reset <= 1'b0;
      for (k = 0; k < 9; k++) rd(8'(4 * k), 8'h00, RESP_OKAY);
      rd(8'h24, 8'h00, RESP_SLVERR);
      wr(OFF_CONTROL_B, 8'hF7);
      chk(32'({o_bipolar_select, o_comparator_mux_on}), 32'h3);
      rd(OFF_CONTROL_B, 8'hF7, RESP_OKAY);
      wr(OFF_INPUT_OFF_1, 8'h70);
      rd(OFF_INPUT_OFF_1, 8'h70, RESP_OKAY);
      wr(OFF_MISC, 8'h07);
      rd(OFF_MISC, 8'h07, RESP_OKAY);
      chk(32'(o_reference), 32'h7);
      wr(OFF_INPUT_OFF_0, 8'h0F);
      wr(OFF_INPUT_OFF_1, 8'h50);
      chk(32'(o_pin_read), 32'h2F0);
      wr(OFF_CONTROL_B, 8'h00);
      wr(OFF_CONTROL_A, 8'h80);
      conv(10'h2A5, 1'b0);
      rd(OFF_RESULT_LOW, 8'hA5, RESP_OKAY);
      rd(OFF_RESULT_HIGH, 8'h02, RESP_OKAY);
      wr(OFF_MUX, 8'h2B);
      chk(32'(o_channel_select), 32'hB);
      rd(OFF_RESULT_HIGH, 8'hA9, RESP_OKAY);
      rd(OFF_RESULT_LOW, 8'h40, RESP_OKAY);
      conv(10'h155, 1'b0);
      rd(OFF_RESULT_HIGH, 8'hA9, RESP_OKAY);
      rd(OFF_RESULT_HIGH, 8'hA9, RESP_OKAY);
      wr(OFF_MUX, 8'h00);
      conv(10'h010, 1'b1);
      rd(OFF_RESULT_LOW, 8'hFF, RESP_OKAY);
      rd(OFF_RESULT_HIGH, 8'h03, RESP_OKAY);
      wr(OFF_CONTROL_B, 8'h80);
      conv(10'h3F0, 1'b1);
      rd(OFF_RESULT_LOW, 8'hF0, RESP_OKAY);
      rd(OFF_RESULT_HIGH, 8'h03, RESP_OKAY);
      // Auto trigger off: a rising flag must not start anything.
      wr(OFF_CONTROL_B, 8'h01);
      s = starts;
      i_trigger_flags <= 8'h02;
      repeat (3) @(posedge i_mclk);
      i_trigger_flags <= 8'h00;
      repeat (2) @(posedge i_mclk);
      chk(starts - s, 0);
      wr(OFF_CONTROL_A, 8'hA0);
      for (k = 1; k < TRIG_COUNT; k++) begin
         wr(OFF_CONTROL_B, 8'(k));
         s = starts;
         i_trigger_flags <= 8'(1 << k);
         repeat (3) @(posedge i_mclk);
         i_trigger_flags <= 8'h00;
         repeat (8) @(posedge i_mclk);
         chk(starts - s, 1);
      end
      i_trigger_flags <= 8'h04;
      s = starts;
      wr(OFF_CONTROL_B, 8'h02);
      repeat (2) @(posedge i_mclk);
      chk(starts - s, 1);
      i_trigger_flags <= 8'h00;
      repeat (8) @(posedge i_mclk);
      s = starts;
      wr(OFF_CONTROL_B, 8'h00);
      repeat (8) @(posedge i_mclk);
      chk(starts - s, 0);
      wr(OFF_CONTROL_A, 8'h80);
      // Comparator modes toggle, none, fall and rise over one rise and one fall.
      for (k = 0; k < 4; k++) begin
         i_cmp_mode <= 2'(k);
         s = events;
         @(posedge i_mclk);
         i_cmp_pos_higher <= 1'b1;
         repeat (4) @(posedge i_mclk);
         chk(32'(o_comparator_out), 32'h1);
         i_cmp_pos_higher <= 1'b0;
         repeat (4) @(posedge i_mclk);
         chk(events - s, (k == 0) ? 2 : (k == 1) ? 0 : 1);
      end
      results();
   end
endmodule : arr_regs_tb
